// file: pulse_source_model.sv
// Model of the external capture pins and serial receive lines.
`timescale 1ns/1ps
module pulse_source_model (
   input wire logic clk,
   output logic [3:0] line_q
);
   // Receive lines idle at the mark level, capture pins idle low.
   initial line_q = 4'b1100;
   // Each toggle is one edge; callers keep a gap after a run enable so no trigger lands on it.
   task automatic toggle(input int idx, input int gap);
      repeat (gap) @(posedge clk);
      line_q[idx] <= ~line_q[idx];
   endtask
endmodule

// file: pulse_width_capture.sv
// Pulse-width-measurement timer channel with Wishbone register slave.
`timescale 1ns/1ps

// Behaviour
// R1 - Mode field 110 selects pulse width measurement.
// R2 - Counter increments each clock once run enable is set.
// R3 - Valid edge copies counter into capture register, clears counter, raises capture interrupt.
// R4 - Software uses one capture input and sets the other to no edge.
// R5 - Past FFFFH counter wraps to 0000H, sets overflow flag and interrupt.
// R6 - Overflow flag cleared by writing 0 to bit 0 of option register.
// R7 - Software computes width from captured value plus overflows times 10000H.
// R8 - No timer waveform on output pins in this mode.
// R9 - Level bit 0: low when disabled or stopped, high once counting.
// R10 - Level bit 1: high when disabled or stopped, low once counting.
// R11 - Source bits 4 and 3 route pins or UART receive lines to capture inputs.
// R12 - Source select register is 8 bits, byte or bit access, resets to 00H.
// R13 - Software disables timer and UART before changing source selection.
// R14 - Software sets capture edge settings before connecting through the selector.
// R15 - Software avoids a trigger right after enabling with slow count clocks.
// R16 - Overflow flag stays set until software clears it.
module pulse_width_capture
   import pwm_capture_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic first_capture_pin,
   input wire logic second_capture_pin,
   input wire logic first_uart_receive,
   input wire logic second_uart_receive,
   output logic [1:0] timer_output_pin,
   output logic capture_irq0,
   output logic capture_irq1,
   output logic overflow_irq,
   output logic irq
);

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic timer_run_enable_q;
   logic [2:0] operating_mode_field_q;
   logic [3:0] edge_select_reg_q;
   logic [3:0] output_control_reg_q;
   logic overflow_flag_q;
   logic [15:0] capture_value_reg_q [2];
   logic [7:0] capture_source_select_q;
   logic [2:0] irq_stat_q;
   logic [2:0] irq_mask_q;
   logic [15:0] count_q;
   logic counting_q;
   wb_req_t req;
   logic wr_stb;
   logic rd_stb;

   assign req = '{adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i, we: wb_we_i, req: wb_cyc_i & wb_stb_i};
   assign wr_stb = clk_en & req.req & req.we & ~wb_ack_o & req.sel[0];
   assign rd_stb = clk_en & req.req & ~wb_ack_o;

   function automatic logic wr_hit(input wb_req_t r, input logic [7:0] a);
      wr_hit = (r.adr == a);
   endfunction

   // ---------------------------------------------------------------
   // Input synchronisers and source selection
   // ---------------------------------------------------------------
   logic [3:0] raw_in;
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic [3:0] sync3_q;
   logic [3:0] level_q;
   logic [1:0] cap_in;
   logic [1:0] cap_prev_q;
   logic [1:0] cap_edge;

   assign raw_in = {second_uart_receive, first_uart_receive, second_capture_pin, first_capture_pin};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= '0;
         sync2_q <= '0;
         sync3_q <= '0;
         level_q <= '0;
      end else if (clk_en) begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         for (int i = 0; i < 4; i++) begin
            if (sync2_q[i] == sync3_q[i]) begin
               level_q[i] <= sync3_q[i];
            end
         end
      end
   end

   assign cap_in[0] = capture_source_select_q[FIRST_SRC_BIT] ? level_q[2] : level_q[0]; // R11
   assign cap_in[1] = capture_source_select_q[SECOND_SRC_BIT] ? level_q[3] : level_q[1]; // R11

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cap_prev_q <= '0;
      end else if (clk_en) begin
         cap_prev_q <= cap_in;
      end
   end

   // Edge detection per input; EDGE_NONE silences an unused input.
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_edge
         edge_sel_t es;
         assign es = edge_sel_t'(edge_select_reg_q[2*g +: 2]);
         assign cap_edge[g] = ((es == EDGE_RISE || es == EDGE_BOTH) && cap_in[g] && !cap_prev_q[g]) ||
                              ((es == EDGE_FALL || es == EDGE_BOTH) && !cap_in[g] && cap_prev_q[g]);
      end
   endgenerate

   // ---------------------------------------------------------------
   // Counter and capture
   // ---------------------------------------------------------------
   logic active;
   logic ovf_event;
   logic [1:0] cap_event;

   assign active = timer_run_enable_q && (operating_mode_field_q == MODE_PULSE_WIDTH); // R1
   assign cap_event = active ? cap_edge : 2'b00;
   assign ovf_event = active && (cap_event == 2'b00) && (count_q == COUNT_MAX);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= COUNT_ZERO;
         counting_q <= 1'b0;
      end else if (clk_en) begin
         counting_q <= active;
         if (!active) begin
            count_q <= COUNT_ZERO;
         end else if (cap_event != 2'b00) begin
            count_q <= COUNT_ZERO; // R3
         end else begin
            count_q <= count_q + 16'h0001; // R2 R5
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         capture_value_reg_q[0] <= COUNT_ZERO;
         capture_value_reg_q[1] <= COUNT_ZERO;
      end else if (clk_en) begin
         for (int i = 0; i < 2; i++) begin
            if (cap_event[i]) begin
               capture_value_reg_q[i] <= count_q; // R3
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Overflow flag
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         overflow_flag_q <= 1'b0;
      end else if (clk_en) begin
         if (ovf_event) begin
            overflow_flag_q <= 1'b1; // R5 R16
         end else if (wr_stb && wr_hit(req, ADDR_OPTION) && !req.dat[OVF_BIT]) begin
            overflow_flag_q <= 1'b0; // R6
         end
      end
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_run_enable_q <= 1'b0;
         operating_mode_field_q <= 3'b000;
         edge_select_reg_q <= 4'h0;
         output_control_reg_q <= 4'h0;
         capture_source_select_q <= BYTE_RESET; // R12
         irq_mask_q <= IRQ_NONE;
      end else if (wr_stb) begin
         if (wr_hit(req, ADDR_CTRL)) begin
            timer_run_enable_q <= req.dat[RUN_BIT];
         end
         if (wr_hit(req, ADDR_MODE)) begin
            operating_mode_field_q <= req.dat[2:0];
         end
         if (wr_hit(req, ADDR_EDGE)) begin
            edge_select_reg_q <= req.dat[3:0];
         end
         if (wr_hit(req, ADDR_OUTCTL)) begin
            output_control_reg_q <= req.dat[3:0];
         end
         if (wr_hit(req, ADDR_SRCSEL)) begin
            capture_source_select_q <= req.dat[7:0] & SRCSEL_MASK; // R12
         end
         if (wr_hit(req, ADDR_IRQ_MASK)) begin
            irq_mask_q <= req.dat[2:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // Interrupt status, set wins over write-one-to-clear
   // ---------------------------------------------------------------
   logic [2:0] irq_set;
   logic [2:0] irq_clr;

   assign irq_set = {ovf_event, cap_event};
   assign irq_clr = (wr_stb && wr_hit(req, ADDR_IRQ_STAT)) ? req.dat[2:0] : IRQ_NONE;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_q <= IRQ_NONE;
      end else if (clk_en) begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         capture_irq0 <= 1'b0;
         capture_irq1 <= 1'b0;
         overflow_irq <= 1'b0;
         irq <= 1'b0;
      end else if (clk_en) begin
         capture_irq0 <= cap_event[0]; // R3
         capture_irq1 <= cap_event[1]; // R3
         overflow_irq <= ovf_event; // R5
         irq <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
      end
   end

   // ---------------------------------------------------------------
   // Timer output pins: static levels only in this mode
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_output_pin <= 2'b00;
      end else if (clk_en) begin
         for (int i = 0; i < 2; i++) begin
            // Inactive level is the level bit; once counting it inverts only if the pin's enable bit (2*i) is set, never a waveform.
            timer_output_pin[i] <= output_control_reg_q[2*i+1] ^
                                   (output_control_reg_q[2*i] & counting_q & active); // R8 R9 R10
         end
      end
   end

   // ---------------------------------------------------------------
   // Wishbone slave: one wait state, ack for every address
   // ---------------------------------------------------------------
   logic [31:0] rd_data;

   always_comb begin
      rd_data = '0;
      unique case (req.adr)
         ADDR_CTRL: rd_data[RUN_BIT] = timer_run_enable_q;
         ADDR_MODE: rd_data[2:0] = operating_mode_field_q;
         ADDR_EDGE: rd_data[3:0] = edge_select_reg_q;
         ADDR_OUTCTL: rd_data[3:0] = output_control_reg_q;
         ADDR_OPTION: rd_data[OVF_BIT] = overflow_flag_q;
         ADDR_CAP0: rd_data[15:0] = capture_value_reg_q[0];
         ADDR_CAP1: rd_data[15:0] = capture_value_reg_q[1];
         ADDR_SRCSEL: rd_data[7:0] = capture_source_select_q;
         ADDR_IRQ_STAT: rd_data[2:0] = irq_stat_q;
         ADDR_IRQ_MASK: rd_data[2:0] = irq_mask_q;
         ADDR_COUNT: rd_data[15:0] = count_q;
         default: rd_data = '0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else if (clk_en) begin
         wb_ack_o <= rd_stb;
         if (rd_stb && !req.we) begin
            wb_dat_o <= rd_data;
         end
      end
   end

endmodule

// file: pwm_capture_pkg.sv
// Package with register map, field positions and types of the pulse-width capture channel.
package pwm_capture_pkg;

   // ---------------------------------------------------------------
   // Register byte addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_MODE = 8'h04;
   localparam logic [7:0] ADDR_EDGE = 8'h08;
   localparam logic [7:0] ADDR_OUTCTL = 8'h0C;
   localparam logic [7:0] ADDR_OPTION = 8'h10;
   localparam logic [7:0] ADDR_CAP0 = 8'h14;
   localparam logic [7:0] ADDR_CAP1 = 8'h18;
   localparam logic [7:0] ADDR_SRCSEL = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;
   localparam logic [7:0] ADDR_COUNT = 8'h28;

   // ---------------------------------------------------------------
   // Field positions and values
   // ---------------------------------------------------------------
   localparam int RUN_BIT = 0;
   localparam int OVF_BIT = 0;
   localparam int FIRST_SRC_BIT = 3;
   localparam int SECOND_SRC_BIT = 4;
   localparam int OE0_BIT = 0;
   localparam int OL0_BIT = 1;
   localparam int OE1_BIT = 2;
   localparam int OL1_BIT = 3;
   localparam int IRQ_CAP0_BIT = 0;
   localparam int IRQ_CAP1_BIT = 1;
   localparam int IRQ_OVF_BIT = 2;
   localparam logic [2:0] MODE_PULSE_WIDTH = 3'b110;
   localparam logic [7:0] SRCSEL_MASK = 8'h18;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [2:0] IRQ_NONE = 3'b000;

   typedef enum logic [1:0] {
      EDGE_NONE = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_FALL = 2'b10,
      EDGE_BOTH = 2'b11
   } edge_sel_t;

   typedef struct packed {
      logic [7:0] adr;
      logic [31:0] dat;
      logic [3:0] sel;
      logic we;
      logic req;
   } wb_req_t;

endpackage

// file: timer_pulse_width_capture_properties.sv
// Port-level assertions for the pulse-width capture channel.
`timescale 1ns/1ps
module pwc_checker (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic wb_ack_o,
   input wire logic [1:0] timer_output_pin,
   input wire logic capture_irq0,
   input wire logic overflow_irq,
   input wire logic irq
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   wire wr_req = wb_cyc_i && wb_we_i;
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   // Only a register write may move the pins or drop irq; two idle cycles cover the register stages.
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_answer_a: assert property (wb_cyc_i && wb_stb_i && clk_en && !wb_ack_o |=> wb_ack_o)
      else $error("request not acked");
   cap_pulse_a: assert property (capture_irq0 |=> !capture_irq0)
      else $error("capture pulse too long");
   ovf_gap_a: assert property (overflow_irq |=> !overflow_irq [*8])
      else $error("overflow too soon");
   ovf_excl_a: assert property (!(capture_irq0 && overflow_irq))
      else $error("overflow with capture");
   irq_sticky_a: assert property (irq && !wr_req |=> irq)
      else $error("irq dropped without write");
   pin_static_a: assert property ((!wr_req) [*2] |=> $stable(timer_output_pin))
      else $error("output pin waveform");
   reset_idle_a: assert property ($rose(rst_n) |-> !wb_ack_o && !irq && timer_output_pin == 2'b00)
      else $error("outputs not idle after reset");
   cover property (capture_irq0);
   cover property (overflow_irq);
   cover property ($fell(irq));
endmodule

bind pulse_width_capture pwc_checker chk_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .timer_output_pin(timer_output_pin),
   .capture_irq0(capture_irq0), .overflow_irq(overflow_irq), .irq(irq));

// file: timer_pulse_width_capture_tb_top.sv
// Self-checking testbench of the pulse-width capture channel.
`timescale 1ns/1ps
module timer_pulse_width_capture_tb_top;
   import pwm_capture_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic [3:0] sel = 4'h0;
   logic en = 1'b1;
   logic [31:0] dat_o, rd, c1;
   logic ack, cap0, cap1, ovf, irq;
   logic [1:0] pins;
   logic [3:0] lines;
   logic [2:0] ev;
   int miscompares = 0;
   int n_checks = 0;
   int n;
   assign ev = {ovf, cap1, cap0};
   always #50 clk = ~clk;
   pulse_width_capture dut_u (.clk(clk), .rst_n(rst_n), .clk_en(en), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .first_capture_pin(lines[0]), .second_capture_pin(lines[1]), .first_uart_receive(lines[2]),
      .second_uart_receive(lines[3]), .timer_output_pin(pins), .capture_irq0(cap0), .capture_irq1(cap1),
      .overflow_irq(ovf), .irq(irq));
   pulse_source_model src_u (.clk(clk), .line_q(lines));
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      chk("ack", k < 20, 1'b1);
   endtask
   task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
      bus(a, 1'b0, 32'h0000_0000);
      chk(s, rd, e);
   endtask
   task automatic wait_irq(input int i, input int lim);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ev[i] !== 1'b1 && n < lim);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d, miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   task automatic t_setup;
      rdc("srcsel reset", ADDR_SRCSEL, 8'h00);
      rdc("unmapped", 8'hFC, 8'h00);
      bus(ADDR_EDGE, 1'b1, 8'h03);
      bus(ADDR_IRQ_MASK, 1'b1, 8'h07);
      bus(ADDR_CTRL, 1'b1, 8'h01);
      src_u.toggle(0, 10);
      wait_irq(0, 30);
      chk("capture outside mode", n < 30, 1'b0);
      bus(ADDR_MODE, 1'b1, MODE_PULSE_WIDTH);
      bus(ADDR_COUNT, 1'b0, 8'h00);
      c1 = rd;
      rdc("count step", ADDR_COUNT, c1 + 32'h0000_0003);
      $display("setup test done");
   endtask
   task automatic t_capture;
      fork
         begin
            src_u.toggle(0, 20);
            src_u.toggle(0, 200);
            src_u.toggle(0, 300);
         end
         begin
            wait_irq(0, 100);
            wait_irq(0, 300);
            bus(ADDR_CAP0, 1'b0, 8'h00);
            c1 = rd;
            wait_irq(0, 400);
            bus(ADDR_CAP0, 1'b0, 8'h00);
         end
      join
      chk("capture interval", rd - c1, 32'h0000_0064);
      $display("capture test done");
   endtask
   task automatic t_overflow;
      src_u.toggle(0, 10);
      wait_irq(0, 100);
      wait_irq(2, 70000);
      chk("wrap time", n >= 65534 && n <= 65536, 1'b1);
      rdc("flag set", ADDR_OPTION, 8'h01);
      src_u.toggle(0, 10);
      wait_irq(0, 100);
      rdc("flag kept", ADDR_OPTION, 8'h01);
      bus(ADDR_OPTION, 1'b1, 8'h01);
      rdc("flag after one", ADDR_OPTION, 8'h01);
      bus(ADDR_OPTION, 1'b1, 8'h00);
      rdc("flag cleared", ADDR_OPTION, 8'h00);
      $display("overflow test done");
   endtask
   task automatic t_irq;
      rdc("status", ADDR_IRQ_STAT, 8'h05);
      chk("irq set", irq, 1'b1);
      bus(ADDR_IRQ_MASK, 1'b1, 8'h00);
      repeat (3) @(posedge clk);
      chk("irq masked", irq, 1'b0);
      bus(ADDR_IRQ_MASK, 1'b1, 8'h07);
      repeat (3) @(posedge clk);
      chk("irq unmasked", irq, 1'b1);
      bus(ADDR_IRQ_STAT, 1'b1, 8'h07);
      repeat (3) @(posedge clk);
      chk("irq cleared", irq, 1'b0);
      $display("interrupt test done");
   endtask
   task automatic t_select;
      for (int i = 0; i < 2; i++) begin
         bus(ADDR_CTRL, 1'b1, 8'h00);
         bus(ADDR_EDGE, 1'b1, 8'h03 << (2 * i));
         bus(ADDR_SRCSEL, 1'b1, 8'h08 << i);
         rdc("srcsel", ADDR_SRCSEL, 8'h08 << i);
         bus(ADDR_CTRL, 1'b1, 8'h01);
         src_u.toggle(i, 10);
         wait_irq(i, 40);
         chk("pin while routed away", n < 40, 1'b0);
         src_u.toggle(i + 2, 10);
         wait_irq(i, 40);
         chk("receive line routed", n < 40, 1'b1);
      end
      bus(ADDR_SRCSEL, 1'b1, 8'hFF);
      rdc("srcsel fixed bits", ADDR_SRCSEL, 8'h18);
      $display("selector test done");
   endtask
   task automatic t_pins;
      bus(ADDR_CTRL, 1'b1, 8'h00);
      bus(ADDR_OUTCTL, 1'b1, 8'h09);
      repeat (3) @(posedge clk);
      chk("pins stopped", pins, 2'b10);
      bus(ADDR_CTRL, 1'b1, 8'h01);
      repeat (3) @(posedge clk);
      chk("pins running", pins, 2'b11);
      bus(ADDR_OUTCTL, 1'b1, 8'h0D);
      repeat (50) @(posedge clk);
      chk("pins steady", pins, 2'b01);
      $display("output pin test done");
   endtask
   // The enable drops between bus calls only, so no request waits on a frozen slave.
   task automatic t_freeze;
      bus(ADDR_COUNT, 1'b0, 32'h0000_0000);
      c1 = rd;
      @(posedge clk);
      en <= 1'b0;
      repeat (20) @(posedge clk);
      en <= 1'b1;
      rdc("count frozen", ADDR_COUNT, c1 + 32'h0000_0004);
      $display("clock enable test done");
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_setup;
      t_capture;
      t_overflow;
      t_irq;
      t_select;
      t_pins;
      t_freeze;
      tally_and_finish;
   end
   initial begin
      #9_000_000;
      miscompares++;
      tally_and_finish;
   end
endmodule
